// ### shared/spi_otp_pkg.sv
package spi_otp_pkg;

   // ----------------------------------------------------------------
   // Array and link geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int OPCODE_W = 8;
   localparam int PIN_COUNT = 4;

   // ----------------------------------------------------------------
   // Instruction codes, compared after the don't-care bit is masked
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_MASK = 8'hf7;
   localparam logic [7:0] OP_MEM_READ = 8'h03;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_IDENT_READ = 8'h15;

   // ----------------------------------------------------------------
   // Fixed answers and counter end points
   // ----------------------------------------------------------------
   localparam logic [7:0] STATUS_CODE = 8'h8c;
   localparam logic [3:0] BIT_CNT_RESET = 4'h0;
   localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
   localparam logic [3:0] ADDR_LAST_BIT = 4'hf;
   localparam logic [15:0] ROM_ADDR_RESET = 16'h0000;
   localparam logic [15:0] ADDR_STEP = 16'h0001;

   // ----------------------------------------------------------------
   // Pin group and decoder states
   // ----------------------------------------------------------------
   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic hold_n;
   } spi_pins_t;

   localparam spi_pins_t PINS_RESET = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1};

   typedef enum logic [6:0] {
      ST_IDLE   = 7'b0000001,
      ST_OPCODE = 7'b0000010,
      ST_DUMMY  = 7'b0000100,
      ST_ADDR   = 7'b0001000,
      ST_READ   = 7'b0010000,
      ST_STATUS = 7'b0100000,
      ST_IDENT  = 7'b1000000
   } dec_state_t;

   // Unsupported opcodes park in idle; a flag keeps decoding shut until deselect
   localparam dec_state_t ST_IGNORE = ST_IDLE;

endpackage

// ### src/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk_in,               // System clock
   input wire logic rst_in,               // Synchronous reset, active high
   input wire logic [WIDTH-1:0] d_in,     // Asynchronous pin levels
   output logic [WIDTH-1:0] q_out         // Levels after two flip-flops
);

   logic [WIDTH-1:0] meta;

   // ----------------------------------------------------------------
   // Two-stage synchroniser, first stage read only by the second
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always_ff @(posedge clk_in) begin
            if (rst_in) begin
               meta[i] <= RESET_VAL[i];
               q_out[i] <= RESET_VAL[i];
            end else begin
               meta[i] <= d_in[i];
               q_out[i] <= meta[i];
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// ### src/spi_otp_read_port.sv
// Notes on behaviour
// - Only memory read, status read and identity read are decoded.
// - Unsupported opcode: stay silent, SO undriven until deselected.
// - Instruction starts at chip select fall: 8-bit opcode, then for memory read a dummy byte and address.
// - While selected, opcode and address bits shift in from SI on SCK.
// - Everything on the link travels most significant bit first.
// - Pause input freezes the link, keeping bit position and state.
// - Works in SPI modes 0 and 3, sampling SI on rising edges.
// - Array holds 65536 bytes, picked by a 16-bit address.
// - Serial pins answer only while chip select is low.
// - Read: opcode, dummy byte, A15..A0, then data out, SI ignored.
// - Read address increments per byte and wraps to zero.
// - Status read returns 8CH repeatedly, MSB first.
// - Identity read returns maker code then device code.
`timescale 1ns/100ps
`default_nettype none

module spi_otp_read_port
   import spi_otp_pkg::*;
#(
   parameter logic [7:0] MFR_CODE = 8'h5a,   // Arbitrary value
   parameter logic [7:0] DEV_CODE = 8'ha5    // Arbitrary value
) (
   input wire logic clk_in,                  // System clock, 100 MHz
   input wire logic rst_in,                  // Synchronous reset, active high
   input wire logic cs_n_in,                 // Chip select pin, active low
   input wire logic sck_in,                  // Serial clock pin
   input wire logic si_in,                   // Serial data in pin
   input wire logic hold_n_in,               // Pause pin, active low
   input wire logic [DATA_W-1:0] rom_data_in, // Array byte at rom_addr_out
   output logic so_out,                      // Serial data out level
   output logic so_oe_out,                   // Serial out enable, high drives
   output logic [ADDR_W-1:0] rom_addr_out    // Array byte address
);

   spi_pins_t raw_pins;
   spi_pins_t pins_s;
   logic sck_d;
   logic active;
   logic rise;
   logic fall;
   dec_state_t state;
   logic [3:0] bit_cnt;
   logic [ADDR_W-1:0] shift_in;
   logic [OPCODE_W-1:0] opcode;
   logic started;
   logic opened;
   logic ident_second;
   logic is_data;
   logic [DATA_W-1:0] tx_byte;

   // ----------------------------------------------------------------
   // Pin synchronisation and serial clock edges
   // ----------------------------------------------------------------
   assign raw_pins = '{cs_n: cs_n_in, sck: sck_in, si: si_in, hold_n: hold_n_in};

   pin_sync #(
      .WIDTH(PIN_COUNT),
      .RESET_VAL(PINS_RESET)
   ) u_pin_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .d_in(raw_pins),
      .q_out(pins_s)
   );

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sck_d <= PINS_RESET.sck;
      end else begin
         sck_d <= pins_s.sck;
      end
   end

   // pause gates edges
   // Edges seen during a pause are dropped, so they cannot advance state
   assign active = !pins_s.cs_n && pins_s.hold_n;
   assign rise = active && pins_s.sck && !sck_d;
   assign fall = active && !pins_s.sck && sck_d;

   assign opcode = {shift_in[OPCODE_W-2:0], pins_s.si};
   assign is_data = (state == ST_READ) || (state == ST_STATUS) || (state == ST_IDENT);

   function automatic dec_state_t decode(input logic [OPCODE_W-1:0] op);
      logic [OPCODE_W-1:0] masked;
      masked = op & OP_MASK;
      if (masked == OP_MEM_READ) begin
         decode = ST_DUMMY;
      end else if (masked == OP_STATUS_READ) begin
         decode = ST_STATUS;
      end else if (masked == OP_IDENT_READ) begin
         decode = ST_IDENT;
      end else begin
         decode = ST_IGNORE;
      end
   endfunction

   // ----------------------------------------------------------------
   // Instruction sequencer
   // ----------------------------------------------------------------
   // deselect rearms decoder
   always_ff @(posedge clk_in) begin
      if (rst_in || pins_s.cs_n) begin
         state <= ST_IDLE;
         bit_cnt <= BIT_CNT_RESET;
      end else if (state == ST_IDLE && !opened) begin
         state <= ST_OPCODE;
         bit_cnt <= BIT_CNT_RESET;
      end else if (rise) begin
         case (state)
            ST_OPCODE: begin
               if (bit_cnt[2:0] == BYTE_LAST_BIT) begin
                  state <= decode(opcode);
                  bit_cnt <= BIT_CNT_RESET;
               end else begin
                  bit_cnt <= bit_cnt + 4'h1;
               end
            end
            ST_DUMMY: begin
               if (bit_cnt[2:0] == BYTE_LAST_BIT) begin
                  state <= ST_ADDR;
                  bit_cnt <= BIT_CNT_RESET;
               end else begin
                  bit_cnt <= bit_cnt + 4'h1;
               end
            end
            ST_ADDR: begin
               if (bit_cnt == ADDR_LAST_BIT) begin
                  state <= ST_READ;
                  bit_cnt <= BIT_CNT_RESET;
               end else begin
                  bit_cnt <= bit_cnt + 4'h1;
               end
            end
            ST_READ, ST_STATUS, ST_IDENT: begin
               bit_cnt <= {1'b0, bit_cnt[2:0] + 3'h1};
            end
            default: begin
               bit_cnt <= bit_cnt;
            end
         endcase
      end
   end

   // park until deselect
   // Only one opcode per selection: after an unsupported one the idle
   // state must not reopen the opcode phase, or trailing bits would decode
   always_ff @(posedge clk_in) begin
      if (rst_in || pins_s.cs_n) begin
         opened <= 1'b0;
      end else if (state == ST_IDLE) begin
         opened <= 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || pins_s.cs_n) begin
         shift_in <= ROM_ADDR_RESET;
      end else if (rise && (state == ST_OPCODE || state == ST_ADDR)) begin
         shift_in <= {shift_in[ADDR_W-2:0], pins_s.si};
      end
   end

   // ----------------------------------------------------------------
   // Array address counter
   // ----------------------------------------------------------------
   // 16-bit byte address
   // increment with wrap
   // Address moves on the last rising edge of a byte so the array has
   // half a serial period to settle before the next byte is loaded
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rom_addr_out <= ROM_ADDR_RESET;
      end else if (rise && state == ST_ADDR && bit_cnt == ADDR_LAST_BIT) begin
         rom_addr_out <= {shift_in[ADDR_W-2:0], pins_s.si};
      end else if (rise && state == ST_READ && bit_cnt[2:0] == BYTE_LAST_BIT) begin
         rom_addr_out <= rom_addr_out + ADDR_STEP;
      end
   end

   // maker then device code
   // After the device code the pair repeats
   always_ff @(posedge clk_in) begin
      if (rst_in || state != ST_IDENT) begin
         ident_second <= 1'b0;
      end else if (rise && bit_cnt[2:0] == BYTE_LAST_BIT) begin
         ident_second <= !ident_second;
      end
   end

   // ----------------------------------------------------------------
   // Serial output
   // ----------------------------------------------------------------
   always_comb begin
      case (state)
         ST_READ: tx_byte = rom_data_in;
         ST_STATUS: tx_byte = STATUS_CODE;
         ST_IDENT: tx_byte = ident_second ? DEV_CODE : MFR_CODE;
         default: tx_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         so_out <= 1'b0;
      end else if (fall && is_data) begin
         so_out <= tx_byte[~bit_cnt[2:0]];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || pins_s.cs_n) begin
         started <= 1'b0;
      end else if (fall && is_data) begin
         started <= 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         so_oe_out <= 1'b0;
      end else begin
         so_oe_out <= active && is_data && (started || fall);
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   sequence opcode_done_s;
      rise && state == ST_OPCODE && bit_cnt[2:0] == BYTE_LAST_BIT;
   endsequence

   sequence read_opcode_s;
      opcode_done_s ##0 ((opcode & OP_MASK) == OP_MEM_READ);
   endsequence

   sequence bad_opcode_s;
      opcode_done_s ##0 (decode(opcode) == ST_IGNORE);
   endsequence

   deselect_quiet_a: assert property (pins_s.cs_n |=> !so_oe_out ##1 !so_oe_out)
      else $error("serial out driven while deselected");
   bad_opcode_a: assert property (bad_opcode_s |=> (!so_oe_out && state == ST_IGNORE) [*3])
      else $error("serial out driven after unsupported opcode");
   select_start_a: assert property ($fell(pins_s.cs_n) |=> state == ST_OPCODE)
      else $error("select fall did not start opcode phase");
   read_decode_a: assert property (read_opcode_s |=> state == ST_DUMMY)
      else $error("memory read opcode not decoded");
   msb_in_a: assert property (rise && state == ST_OPCODE |=> shift_in[0] == $past(pins_s.si))
      else $error("serial input not shifted in at bit zero");
   pause_hold_a: assert property (!pins_s.cs_n && !pins_s.hold_n |=>
      $stable(state) && $stable(bit_cnt) && !so_oe_out)
      else $error("state moved during pause");
   fall_no_sample_a: assert property (fall |=> $stable(bit_cnt) && $stable(shift_in))
      else $error("falling edge advanced input");
   addr_wrap_a: assert property (rise && state == ST_READ && bit_cnt[2:0] == BYTE_LAST_BIT
      |=> rom_addr_out == $past(rom_addr_out) + ADDR_STEP)
      else $error("read address did not step");
   status_bit_a: assert property (fall && state == ST_STATUS
      |=> so_out == STATUS_CODE[~$past(bit_cnt[2:0])])
      else $error("status bit wrong");
   deselect_rearm_a: assert property (pins_s.cs_n |=> state == ST_IDLE && bit_cnt == 4'h0)
      else $error("deselect did not rearm decoder");

endmodule

`default_nettype wire

// ### bench/spi_host.sv
`timescale 1ns/100ps
`default_nettype none

module spi_host
   import spi_otp_pkg::*;
(
   input wire logic clk_in,          // System clock
   input wire logic so_in,           // Serial out level from the port
   input wire logic so_oe_in,        // Serial out enable from the port
   output var spi_pins_t pins_out    // Pins driven towards the port
);
   logic last_so;

   initial begin
      pins_out = PINS_RESET;
      last_so = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // SCK is 6 clk high and 7 clk low; SO is read just before each rise
   task automatic xfer(input logic mode3, input logic [63:0] tx, input int n,
                       input int pause_at, output logic [63:0] rx,
                       output logic [63:0] oe, output logic quiet);
      logic lvl;
      rx = '0;
      oe = '0;
      quiet = 1'b1;
      pins_out.sck <= mode3;
      wait_clk(2);
      // select with SCK at its idle level
      pins_out.cs_n <= 1'b0;
      wait_clk(3);
      for (int i = 0; i < n; i++) begin
         // bit set while SCK low, MSB first
         pins_out.sck <= 1'b0;
         pins_out.si <= tx[n-1-i];
         wait_clk(7);
         if (i == pause_at) begin
            pins_out.hold_n <= 1'b0;
            wait_clk(3);
            repeat (2) begin
               pins_out.sck <= 1'b1;
               wait_clk(6);
               pins_out.sck <= 1'b0;
               wait_clk(6);
            end
            quiet = (so_oe_in === 1'b0);
            pins_out.hold_n <= 1'b1;
            wait_clk(6);
         end
         // Released line shows the opposite of its last level
         lvl = (so_oe_in === 1'b1) ? so_in : ~last_so;
         last_so = lvl;
         rx = {rx[62:0], lvl};
         oe = {oe[62:0], so_oe_in};
         pins_out.sck <= 1'b1;
         wait_clk(6);
      end
      pins_out.sck <= mode3;
      wait_clk(3);
      pins_out.cs_n <= 1'b1;
      pins_out.si <= 1'b0;
      wait_clk(6);
   endtask
endmodule

`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
   import spi_otp_pkg::*;
   localparam logic [7:0] MFR = 8'h3c;  // Arbitrary value
   localparam logic [7:0] DEV = 8'hc3;  // Arbitrary value
   logic clk_in;
   logic rst_in;
   spi_pins_t pins;
   logic so;
   logic so_oe;
   logic [ADDR_W-1:0] rom_addr;
   logic [DATA_W-1:0] rom_data;
   logic [63:0] rx;
   logic [63:0] oe;
   logic quiet;
   int bad_count = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [7:0] bad_ops [6] = '{8'h01, 8'h04, 8'h06, 8'h13, 8'h25, 8'hff};

   // ----------------------------------------------------------------
   // Array model, clock and instances
   // ----------------------------------------------------------------
   function automatic logic [7:0] rom_byte(input logic [15:0] a);
      return a[7:0] + {a[11:8], a[15:12]} + 8'h96;
   endfunction

   always @(posedge clk_in) rom_data <= rom_byte(rom_addr);

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   spi_otp_read_port #(.MFR_CODE(MFR), .DEV_CODE(DEV)) dut (
      .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(pins.cs_n), .sck_in(pins.sck),
      .si_in(pins.si), .hold_n_in(pins.hold_n), .rom_data_in(rom_data),
      .so_out(so), .so_oe_out(so_oe), .rom_addr_out(rom_addr));

   spi_host host (.clk_in(clk_in), .so_in(so), .so_oe_in(so_oe), .pins_out(pins));

   // ----------------------------------------------------------------
   // Checks and closing
   // ----------------------------------------------------------------
   task automatic check_data(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_flag(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         bad_count++;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_reset();
      check_flag(so_oe, 1'b0);
      check_data({48'h0, rom_addr}, {48'h0, ROM_ADDR_RESET});
   endtask

   task automatic test_status(input logic mode3, input logic [7:0] op, input int pause_at);
      host.xfer(mode3, {32'h0, op, 24'h0}, 32, pause_at, rx, oe, quiet);
      check_data({40'h0, rx[23:0]}, {40'h0, 24'h8c8c8c});
      check_data({32'h0, oe[31:0]}, {32'h0, 32'h00ff_ffff});
      check_flag(quiet, 1'b1);
      check_flag(so_oe, 1'b0);
   endtask

   task automatic test_ident(input logic mode3, input logic [7:0] op);
      host.xfer(mode3, {32'h0, op, 24'h0}, 32, 99, rx, oe, quiet);
      check_data({40'h0, rx[23:0]}, {40'h0, MFR, DEV, MFR});
   endtask

   task automatic test_read(input logic mode3, input logic [7:0] op, input logic [15:0] a);
      host.xfer(mode3, {op, 8'h5a, a, 32'hffff_ffff}, 64, 99, rx, oe, quiet);
      // Stream with wrap
      check_data({32'h0, rx[31:0]}, {32'h0, rom_byte(a), rom_byte(a + 16'h1),
                 rom_byte(a + 16'h2), rom_byte(a + 16'h3)});
      check_data(oe, {32'h0, 32'hffff_ffff});
   endtask

   task automatic test_unsupported();
      // the programming opcode is never sent
      // A valid opcode follows each bad one: it must not be decoded
      foreach (bad_ops[k]) begin
         host.xfer(1'b0, {32'h0, bad_ops[k], 8'h05, 16'hffff}, 32, 99, rx, oe, quiet);
         check_data(oe, 64'h0);
         test_status(1'b0, 8'h05, 99);
      end
   endtask

   task automatic test_abort();
      host.xfer(1'b0, {28'h0, 8'h03, 8'h00, 16'h4321, 4'hf}, 36, 99, rx, oe, quiet);
      check_data({60'h0, rx[3:0]}, {56'h0, rom_byte(16'h4321) >> 4});
      test_status(1'b1, 8'h05, 99);
   endtask

   initial begin
      rst_in = 1'b1;
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      test_reset();
      test_status(1'b0, 8'h05, 99);
      test_status(1'b1, 8'h0d, 18);
      test_ident(1'b0, 8'h15);
      test_ident(1'b1, 8'h1d);
      test_read(1'b0, 8'h03, 16'hfffe);
      test_read(1'b1, 8'h0b, 16'h1234);
      test_unsupported();
      test_abort();
      end_of_test();
   end
endmodule

`default_nettype wire
